/* hw/hbc_host_bus_control.sv */
// Purpose: host bus control register and the isa-side behaviour it steers
// Assumes: isa pins asynchronous, core handshakes on clk
// Notes: apb slave answers in the second access cycle
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module hbc_host_bus_control #(
  parameter int MEM_BASE_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hbc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hbc_pkg::hbc_pins_t isa_pins,
  input wire logic [MEM_BASE_W-1:0] mem_base,
  input wire logic read_data_late,
  input wire logic rx_frame_pending,
  input wire logic dma_word_done,
  input wire logic cfg_load,
  input wire logic [15:0] cfg_data,
  output logic iochrdy_out,
  output logic iochrdy_oe_n,
  output logic memcs16_n,
  output logic dma_req,
  output logic dma_stretch_en,
  output logic mem_space_open,
  output logic rx_buffer_flush,
  output logic [15:0] rx_dma_offset,
  output logic irq
);
  typedef struct packed {
    hbc_pkg::hbc_pins_t s1;
    hbc_pkg::hbc_pins_t s2;
    logic [15:0] ctrl;
    logic [15:0] rx_off;
    hbc_pkg::hbc_dma_st_t dst;
    logic [hbc_pkg::CNT_W-1:0] cnt;
    logic [hbc_pkg::N_EVT-1:0] ists;
    logic [hbc_pkg::N_EVT-1:0] ien;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic wait_oe_n;
    logic cs16_n;
    logic req;
    logic flush;
  } hbc_state_t;

  hbc_state_t st_r;
  hbc_state_t st_nxt;

  logic acc;
  logic wr;
  logic [11:0] idx;
  logic mapped;
  logic [15:0] wrap;
  logic [hbc_pkg::N_EVT-1:0] evt;
  logic rd_cycle;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign acc = psel && penable && !st_r.ready;
  assign wr = acc && pwrite;
  assign idx = paddr[hbc_pkg::ADDR_W-1:2];
  assign mapped = (idx == hbc_pkg::IDX_HOST_BUS_CONTROL) || (idx == hbc_pkg::IDX_RX_DMA_OFFSET)
    || (idx == hbc_pkg::IDX_IRQ_STATUS) || (idx == hbc_pkg::IDX_IRQ_CLEAR)
    || (idx == hbc_pkg::IDX_IRQ_ENABLE);

  always_comb
  begin
    st_nxt = st_r;
    evt = '0;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    st_nxt.s1 = isa_pins;
    st_nxt.s2 = st_r.s1;

    // ----------------------------------------
    // register access
    // ----------------------------------------
    st_nxt.ready = acc;
    st_nxt.err = acc && !mapped;
    if (acc)
    begin
      st_nxt.rdata = '0;
      if (!pwrite)
      begin
        unique case (idx)
          hbc_pkg::IDX_HOST_BUS_CONTROL:
            st_nxt.rdata[15:0] = {st_r.ctrl[15:6], hbc_pkg::REG_ID};
          hbc_pkg::IDX_RX_DMA_OFFSET: st_nxt.rdata[15:0] = st_r.rx_off;
          hbc_pkg::IDX_IRQ_STATUS: st_nxt.rdata[hbc_pkg::N_EVT-1:0] = st_r.ists;
          hbc_pkg::IDX_IRQ_ENABLE: st_nxt.rdata[hbc_pkg::N_EVT-1:0] = st_r.ien;
          default: st_nxt.rdata = '0;
        endcase
      end
    end
    if (wr && idx == hbc_pkg::IDX_HOST_BUS_CONTROL)
      st_nxt.ctrl = (pwdata[15:0] & hbc_pkg::CTRL_WMASK) | hbc_pkg::CTRL_RESET;
    if (wr && idx == hbc_pkg::IDX_IRQ_ENABLE)
      st_nxt.ien = pwdata[hbc_pkg::N_EVT-1:0];
    // configuration memory overrides the writable bits, identifier kept
    if (cfg_load)
      st_nxt.ctrl = (cfg_data & hbc_pkg::CTRL_WMASK) | hbc_pkg::CTRL_RESET;

    // ----------------------------------------
    // receive dma sequencing
    // ----------------------------------------
    wrap = st_r.ctrl[hbc_pkg::B_RX_DMA_SIZE] ? hbc_pkg::WRAP_LARGE : hbc_pkg::WRAP_SMALL;
    if (dma_word_done && st_r.dst == hbc_pkg::DMA_BURST)
      st_nxt.rx_off = (st_r.rx_off + hbc_pkg::DMA_STEP) & wrap;
    if (st_r.cnt != '0)
      st_nxt.cnt = st_r.cnt - 1'b1;
    unique case (st_r.dst)
      hbc_pkg::DMA_IDLE:
        if (rx_frame_pending)
        begin
          st_nxt.dst = hbc_pkg::DMA_BURST;
          st_nxt.cnt = hbc_pkg::CNT_W'(hbc_pkg::TENURE_CYC - 1);
        end
      hbc_pkg::DMA_BURST:
        if (!rx_frame_pending)
        begin
          // continuous transfer ends only with the frame
          st_nxt.dst = hbc_pkg::DMA_IDLE;
          evt[hbc_pkg::EVT_FRAME_MOVED] = 1'b1;
        end
        else if (st_r.ctrl[hbc_pkg::B_TENURE_LIMIT] && st_r.cnt == '0)
        begin
          st_nxt.dst = hbc_pkg::DMA_HOLDOFF;
          st_nxt.cnt = hbc_pkg::CNT_W'(hbc_pkg::HOLDOFF_CYC - 1);
          evt[hbc_pkg::EVT_TENURE_END] = 1'b1;
        end
      hbc_pkg::DMA_HOLDOFF:
        if (st_r.cnt == '0)
          st_nxt.dst = hbc_pkg::DMA_IDLE;
    endcase
    // pointer clear dominates the sequencer and holds while set
    if (st_r.ctrl[hbc_pkg::B_RX_PTR_CLEAR])
    begin
      st_nxt.rx_off = '0;
      st_nxt.dst = hbc_pkg::DMA_IDLE;
      st_nxt.cnt = '0;
    end
    st_nxt.flush = st_r.ctrl[hbc_pkg::B_RX_PTR_CLEAR];
    st_nxt.req = (st_nxt.dst == hbc_pkg::DMA_BURST);

    // ----------------------------------------
    // interrupts: set wins over clear
    // ----------------------------------------
    if (wr && idx == hbc_pkg::IDX_IRQ_CLEAR)
      st_nxt.ists = st_r.ists & ~pwdata[hbc_pkg::N_EVT-1:0];
    st_nxt.ists = st_nxt.ists | evt;
    st_nxt.irq = st_r.ctrl[hbc_pkg::B_IRQ_OUT_EN] && |(st_nxt.ists & st_nxt.ien);

    // ----------------------------------------
    // isa side pins
    // ----------------------------------------
    // only reads outside a dma acknowledge may be stretched
    rd_cycle = (!st_r.s2.ior_n || (!st_r.s2.memr_n && st_r.ctrl[hbc_pkg::B_MEM_ENABLE]))
      && st_r.s2.dack_n;
    st_nxt.wait_oe_n = !(rd_cycle && read_data_late
      && !st_r.ctrl[hbc_pkg::B_WAIT_DISABLE]);
    if (st_r.ctrl[hbc_pkg::B_INT_DECODE])
      st_nxt.cs16_n = !(st_r.ctrl[hbc_pkg::B_MEM_ENABLE]
        && st_r.s2.addr[19 -: MEM_BASE_W] == mem_base);
    else
      st_nxt.cs16_n = st_r.s2.cs_n;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.s1 <= '1;
      st_r.s2 <= '1;
      st_r.ctrl <= hbc_pkg::CTRL_RESET;
      st_r.dst <= hbc_pkg::DMA_IDLE;
      st_r.wait_oe_n <= 1'b1;
      st_r.cs16_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  // wait is only ever driven low; high comes from the pull-up
  assign iochrdy_out = 1'b0;
  assign iochrdy_oe_n = st_r.wait_oe_n;
  assign memcs16_n = st_r.cs16_n;
  assign dma_req = st_r.req;
  assign dma_stretch_en = st_r.ctrl[hbc_pkg::B_DMA_STRETCH];
  assign mem_space_open = st_r.ctrl[hbc_pkg::B_MEM_ENABLE];
  assign rx_buffer_flush = st_r.flush;
  assign rx_dma_offset = st_r.rx_off;
  assign irq = st_r.irq;
endmodule : hbc_host_bus_control

/* inc/hbc_pkg.sv */
// Purpose: constants and types of the host bus control block
// Assumes: 125 MHz clock, APB register access, word index times four is the byte address
// Notes: one aligned 32-bit word per register, at most 16 bits used
package hbc_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int TENURE_NS = 28000;
  localparam int HOLDOFF_NS = 1300;
  // longest time rounds down, least time rounds up
  localparam int TENURE_CYC = TENURE_NS * CLK_MHZ / 1000;
  localparam int HOLDOFF_CYC = (HOLDOFF_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;
  // ----------------------------------------
  // register indexes and address width
  // ----------------------------------------
  localparam logic [11:0] IDX_HOST_BUS_CONTROL = 12'h116;
  localparam logic [11:0] IDX_RX_DMA_OFFSET = 12'h026;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h180;
  localparam logic [11:0] IDX_IRQ_CLEAR = 12'h181;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h182;
  localparam int ADDR_W = 14;
  // ----------------------------------------
  // host_bus_control fields
  // ----------------------------------------
  localparam logic [5:0] REG_ID = 6'h17;
  localparam logic [15:0] CTRL_RESET = 16'h0017;
  localparam logic [15:0] CTRL_WMASK = 16'hBF40;
  localparam int B_RX_PTR_CLEAR = 6;
  localparam int B_DMA_STRETCH = 8;
  localparam int B_INT_DECODE = 9;
  localparam int B_MEM_ENABLE = 10;
  localparam int B_TENURE_LIMIT = 11;
  localparam int B_WAIT_DISABLE = 12;
  localparam int B_RX_DMA_SIZE = 13;
  localparam int B_IRQ_OUT_EN = 15;
  // ----------------------------------------
  // interrupt events and buffer sizes
  // ----------------------------------------
  localparam int N_EVT = 2;
  localparam int EVT_FRAME_MOVED = 0;
  localparam int EVT_TENURE_END = 1;
  localparam logic [15:0] WRAP_SMALL = 16'h3FFF;
  localparam logic [15:0] WRAP_LARGE = 16'hFFFF;
  localparam logic [15:0] DMA_STEP = 16'h0002;

  typedef enum logic [1:0] {DMA_IDLE, DMA_BURST, DMA_HOLDOFF} hbc_dma_st_t;

  // pins from the isa side, strobes and chip select active low, address true
  typedef struct packed {
    logic cs_n;
    logic ior_n;
    logic memr_n;
    logic dack_n;
    logic [19:0] addr;
  } hbc_pins_t;
endpackage : hbc_pkg

/* sim/hbc_checker.sv */
// Purpose: port assertions for the host bus control block
// Assumes: one clock domain, synchronous active low reset
// Notes: bound onto every instance of the block
`timescale 1ns/10ps
module hbc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pready,
  input wire logic pslverr,
  input wire hbc_pkg::hbc_pins_t isa_pins,
  input wire logic read_data_late,
  input wire logic rx_frame_pending,
  input wire logic iochrdy_out,
  input wire logic iochrdy_oe_n,
  input wire logic dma_req,
  input wire logic rx_buffer_flush,
  input wire logic [15:0] rx_dma_offset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  flush_zero_a: assert property (rx_buffer_flush |->
    rx_dma_offset == 16'h0000 ##1 !dma_req) else $error("flush with live dma");
  holdoff_gap_a: assert property ($fell(dma_req) && rx_frame_pending &&
    !rx_buffer_flush |-> !dma_req [*8]) else $error("dma request too soon");
  pin_low_a: assert property (iochrdy_out == 1'b0)
    else $error("wait pin driven high");
  wait_quiet_a: assert property ((!isa_pins.dack_n ||
    isa_pins.ior_n && isa_pins.memr_n) [*4] |-> iochrdy_oe_n) else $error("bad wait");
  wait_late_a: assert property (!read_data_late [*2] |-> iochrdy_oe_n)
    else $error("wait without need");
  offset_even_a: assert property (rx_dma_offset[0] == 1'b0)
    else $error("odd dma offset");
  dma_idle_a: assert property (!rx_frame_pending [*3] |-> !dma_req)
    else $error("dma without frame");
endmodule : hbc_checker
bind hbc_host_bus_control hbc_checker u_chk (.clk, .rst_n, .pready, .pslverr, .isa_pins,
  .read_data_late, .rx_frame_pending, .iochrdy_out, .iochrdy_oe_n, .dma_req,
  .rx_buffer_flush, .rx_dma_offset);

/* sim/hbc_isa_host.sv */
// Purpose: isa host and dma controller model
// Assumes: kind 0 idle, 1 io read, 2 memory read, 3 dma read
// Notes: one word per two cycles while dma is requested
`timescale 1ns/10ps
module hbc_isa_host (
  input wire logic clk,
  input wire logic [1:0] kind,
  input wire logic sel_n,
  input wire logic [19:0] addr,
  input wire logic dma_req,
  output hbc_pkg::hbc_pins_t pins,
  output logic word_done
);
  always_ff @(posedge clk)
    word_done <= dma_req & ~word_done;
  always_comb
  begin
    pins.cs_n = sel_n;
    pins.ior_n = kind != 2'h1;
    pins.memr_n = kind != 2'h2;
    pins.dack_n = kind != 2'h3;
    pins.addr = addr;
  end
endmodule : hbc_isa_host

/* sim/hbc_host_bus_control_bench.sv */
// Purpose: self-checking bench of the host bus control block
// Assumes: apb master in the bench, isa host model on the pins
// Notes: tenure and holdoff counted in clock cycles
`timescale 1ns/10ps
module hbc_host_bus_control_bench;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, late, pend, wdone, sel_n;
  logic cfg_load, iochrdy_out, iochrdy_oe_n, memcs16_n, dma_req, irq, er, flush, mopen;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cfg_data, rx_dma_offset;
  logic [19:0] ad;
  logic [1:0] kind;
  hbc_pkg::hbc_pins_t pins;
  int err_total, cmp_count, cycles, n;
  hbc_host_bus_control u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .isa_pins(pins), .mem_base(8'h5A), .read_data_late(late),
    .rx_frame_pending(pend), .dma_word_done(wdone), .cfg_load, .cfg_data, .iochrdy_out,
    .iochrdy_oe_n, .memcs16_n, .dma_req, .dma_stretch_en(), .mem_space_open(mopen),
    .rx_buffer_flush(flush), .rx_dma_offset, .irq);
  hbc_isa_host u_host (.clk, .kind, .sel_n, .addr(ad), .dma_req, .pins, .word_done(wdone));
  task automatic conclude;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic t_regs;
    apb(1'b0, 14'h0458, 32'h0);
    chk("ctrl reset", rd, 32'h17);
    apb(1'b1, 14'h0458, 32'hFFFFFFFF);
    apb(1'b0, 14'h0458, 32'h0);
    chk("ctrl mask", rd, 32'hBF57);
    chk("flush", flush, 32'h1);
    chk("offset", rx_dma_offset, 32'h0);
    chk("mem open", mopen, 32'h1);
    apb(1'b0, 14'h0004, 32'h0);
    chk("unmapped", er, 32'h1);
  endtask : t_regs
  task automatic t_isa;
    apb(1'b1, 14'h0458, 32'h0);
    sel_n <= 1'b0;
    kind <= 2'h1;
    late <= 1'b1;
    cyc(4);
    chk("memcs ext", memcs16_n, 32'h0);
    chk("wait io", iochrdy_oe_n, 32'h0);
    kind <= 2'h2;
    cyc(4);
    chk("wait mem off", iochrdy_oe_n, 32'h1);
    kind <= 2'h3;
    cyc(4);
    chk("wait dma", iochrdy_oe_n, 32'h1);
    apb(1'b1, 14'h0458, 32'h0600);
    sel_n <= 1'b1;
    kind <= 2'h2;
    ad <= 20'h5A123;
    cyc(4);
    chk("memcs hit", memcs16_n, 32'h0);
    chk("wait mem", iochrdy_oe_n, 32'h0);
    ad <= 20'h12345;
    cyc(4);
    chk("memcs miss", memcs16_n, 32'h1);
    apb(1'b1, 14'h0458, 32'h1600);
    cyc(2);
    chk("wait off", iochrdy_oe_n, 32'h1);
  endtask : t_isa
  task automatic t_dma;
    kind <= 2'h0;
    apb(1'b1, 14'h0608, 32'h3);
    apb(1'b1, 14'h0458, 32'h8800);
    pend <= 1'b1;
    while (dma_req !== 1'b1) @(posedge clk);
    for (n = 0; dma_req === 1'b1; n++) @(posedge clk);
    chk("tenure", n, hbc_pkg::TENURE_CYC);
    for (n = 0; dma_req === 1'b0; n++) @(posedge clk);
    // holdoff count plus the one idle cycle before the next request
    chk("holdoff", n, hbc_pkg::HOLDOFF_CYC + 1);
    chk("irq tenure", irq, 32'h1);
    apb(1'b1, 14'h0604, 32'h3);
    apb(1'b1, 14'h0458, 32'h8000);
    n = 0;
    repeat (4000)
    begin
      @(posedge clk);
      n += (dma_req !== 1'b1);
    end
    chk("dma gaps", n, 32'h0);
    pend <= 1'b0;
    cyc(4);
    chk("dma stop", dma_req, 32'h0);
    apb(1'b0, 14'h0600, 32'h0);
    chk("status", rd, 32'h1);
    chk("irq frame", irq, 32'h1);
    apb(1'b1, 14'h0458, 32'h0);
    cyc(2);
    chk("irq off", irq, 32'h0);
  endtask : t_dma
  task automatic t_cfg;
    cfg_data <= 16'hFFFF;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    apb(1'b0, 14'h0458, 32'h0);
    chk("cfg load", rd, 32'hBF57);
  endtask : t_cfg
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, late, pend, cfg_load, kind} = '0;
    {paddr, pwdata, cfg_data, ad} = '0;
    sel_n = 1'b1;
    cyc(20);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_isa();
    t_dma();
    t_cfg();
    conclude();
  end
endmodule : hbc_host_bus_control_bench
